// ===== fmw_pkg.sv
// Constants, types and register map of the fault monitor block
//
// Contract
// - Alarm low when current output load stays open longer than 500 us.
// - Alarm low when enabled current output lacks compliance longer than 500 us.
// - Alarm low whenever die temperature exceeds +150 C.
// - Alarm low when enabled watchdog times out.
// - Alarm low when enabled frame check finds a bad frame.
// - In voltage mode, alarm low after 500 us at short-circuit limit.
// - Alarm low when converter reaches its selected high-side voltage limit.
// - Alarm is non-latched by default, released once no condition remains.
// - Open load with converter powering output latches alarm until cleared.
// - Response code 10 shuts converter and amplifier; alarm stays non-latched.
// - Read-only supply-good flag set only when every enabled rail is good.
// - Each alarm sets a sticky status flag, cleared by writing one or reset.
// - Status reset lasts at least 8 us; persisting conditions set again.
// - Mask register aligned with status; set bit keeps condition off alarm.
// - Response priority: over-temperature, then output fault, then frame/watchdog.
// - Response 01 sets converter to 6-bit fault code and keeps it.
// - Watchdog enable bit and 2-bit period field, timed from 8 MHz base.
// - Host writes address 0x10 within each period, else alarm and flag.
// - Watchdog flag clears on reset or when watchdog enable written zero.
// - Ramp enable steps output code; 3-bit step and 4-bit rate fields.
// - With ramping, clear input ramps to zero; new data ramps from present code.
// - Disabling ramp mid-way aborts and holds the last code reached.
package fmw_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ         = 200;
  localparam int FILTER_US       = 500;
  localparam int FILTER_CYC_DEF  = FILTER_US * CLK_MHZ;
  localparam int STAT_CLR_NS     = 8000;
  localparam int STAT_CLR_CYC    = (STAT_CLR_NS * CLK_MHZ + 999) / 1000;
  localparam int WDOG_OSC_MHZ    = 8;
  localparam int WDOG_OSC_TICKS  = 80000;
  localparam int WDOG_CYC_DEF    = WDOG_OSC_TICKS * (CLK_MHZ / WDOG_OSC_MHZ);
  localparam int RATE_BASE_DEF   = 40;

  // ************************************************************
  // Serial frame and register map
  // ************************************************************
  localparam int       FRAME_BITS     = 24;
  localparam int       FRAME_RW_BIT   = 23;
  localparam logic [6:0] ADDR_SOFT_RST  = 7'h01;
  localparam logic [6:0] ADDR_CH_SEL    = 7'h03;
  localparam logic [6:0] ADDR_CH_OUT    = 7'h04;
  localparam logic [6:0] ADDR_DAC_DATA  = 7'h05;
  localparam logic [6:0] ADDR_STATUS    = 7'h0b;
  localparam logic [6:0] ADDR_MASK      = 7'h0c;
  localparam logic [6:0] ADDR_ACTION    = 7'h0d;
  localparam logic [6:0] ADDR_CODE      = 7'h0e;
  localparam logic [6:0] ADDR_WDOG_KICK = 7'h10;
  localparam logic [15:0] REG_RST       = 16'h0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CS_WDOG_PER_LO = 0;
  localparam int CS_WDOG_EN     = 2;
  localparam int CS_CRC_EN      = 3;
  localparam int OUT_STEP_LO    = 0;
  localparam int OUT_RAMP_EN    = 4;
  localparam int OUT_RATE_LO    = 8;
  localparam int OUT_CURRENT_OUTPUT_EN    = 12;
  localparam int OUT_CONV_EN    = 13;
  localparam int ACT_OUTPUT_LO  = 0;
  localparam int ACT_TEMP_LO    = 2;
  localparam int ACT_COMM_LO    = 4;
  localparam int CODE_HS_LIMIT  = 5;
  localparam int CODE_LO        = 8;
  localparam int CODE_PAD       = 10;
  localparam int FAULT_BITS     = 7;

  typedef enum logic [1:0] {
    ACT_NONE      = 2'b00,
    ACT_LOAD_CODE = 2'b01,
    ACT_SHUTDOWN  = 2'b10,
    ACT_ZERO      = 2'b11
  } fmw_action_t;

  typedef enum logic {
    ST_RUN   = 1'b0,
    ST_CLEAR = 1'b1
  } fmw_stat_state_t;

  // Status and mask bit order, open load in bit 0
  typedef struct packed {
    logic hsLimit;
    logic shortCkt;
    logic crc;
    logic wdog;
    logic overTemp;
    logic compliance;
    logic openLoad;
  } fmw_fault_t;

  // Analog comparator pins
  typedef struct packed {
    logic negRailOk;
    logic posRailOk;
    logic hsLimit;
    logic shortCkt;
    logic overTemp;
    logic compliance;
    logic openLoad;
  } fmw_sense_t;

endpackage

// ===== fmw_fault_monitor.sv
// Fault supervision, watchdog, serial register port and output code stepper
`timescale 1ns/1ps
module fmw_fault_monitor #(
  parameter int FILTER_CYC    = fmw_pkg::FILTER_CYC_DEF,
  parameter int WDOG_CYC      = fmw_pkg::WDOG_CYC_DEF,
  parameter int RATE_BASE_CYC = fmw_pkg::RATE_BASE_DEF
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Serial register port
  input  wire logic               sclk,
  input  wire logic               syncN,
  input  wire logic               sdin,
  output logic                    sdoO,
  output logic                    sdoOe,
  // Sense inputs
  input  wire fmw_pkg::fmw_sense_t sense,
  input  wire logic               posRailEn,
  input  wire logic               negRailEn,
  input  wire logic               crcErrPulse,
  input  wire logic               clearIn,
  // Alarm pin, open drain
  output logic                    alarmO,
  output logic                    alarmOe,
  // Converter control
  output logic [15:0]             dacCode,
  output logic                    convEn,
  output logic                    ioutEn,
  output logic                    hsLimitSel
);
  import fmw_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int NSYNC = FAULT_BITS + 4;
  localparam logic [NSYNC-1:0] SYNC_RST = {1'b0, 1'b0, 1'b1, 1'b1, 7'h00};

  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] filt_r;

  assign rawIn = {clearIn, sdin, syncN, sclk, sense};

  generate
    for (genvar i = 0; i < NSYNC; i++) begin : gSync
      always_ff @(posedge clk) begin
        if (!rstn) begin
          s1_r[i]   <= SYNC_RST[i];
          s2_r[i]   <= SYNC_RST[i];
          s3_r[i]   <= SYNC_RST[i];
          filt_r[i] <= SYNC_RST[i];
        end else begin
          s1_r[i] <= rawIn[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            filt_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  fmw_sense_t senseF;
  logic       sclkF;
  logic       syncF;
  logic       sdinF;
  logic       clrF;

  assign senseF = fmw_sense_t'(filt_r[FAULT_BITS-1:0]);
  assign sclkF  = filt_r[FAULT_BITS];
  assign syncF  = filt_r[FAULT_BITS+1];
  assign sdinF  = filt_r[FAULT_BITS+2];
  assign clrF   = filt_r[FAULT_BITS+3];

  // ************************************************************
  // Serial frame receiver
  // ************************************************************
  logic        sclkP_r;
  logic        syncP_r;
  logic [23:0] shift_r;
  logic [4:0]  bitCnt_r;
  logic        sclkFall;
  logic        sclkRise;
  logic        syncFall;
  logic        syncRise;
  logic        frameOk;
  logic        wrEn;
  logic        rdReq;
  logic [6:0]  addr;
  logic [15:0] wdata;

  assign sclkFall = sclkP_r & ~sclkF;
  assign sclkRise = ~sclkP_r & sclkF;
  assign syncFall = syncP_r & ~syncF;
  assign syncRise = ~syncP_r & syncF;
  assign frameOk  = syncRise && (bitCnt_r == 5'(FRAME_BITS));
  assign wrEn     = frameOk & ~shift_r[FRAME_RW_BIT];
  assign rdReq    = frameOk & shift_r[FRAME_RW_BIT];
  assign addr     = shift_r[22:16];
  assign wdata    = shift_r[15:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sclkP_r <= 1'b1;
      syncP_r <= 1'b1;
    end else begin
      sclkP_r <= sclkF;
      syncP_r <= syncF;
    end
  end

  // Keeps the last 24 bits; short frames are dropped
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_r  <= 24'h000000;
      bitCnt_r <= 5'h00;
    end else if (syncFall) begin
      bitCnt_r <= 5'h00;
    end else if (!syncF && sclkFall) begin
      shift_r <= {shift_r[22:0], sdinF};
      if (bitCnt_r != 5'(FRAME_BITS)) begin
        bitCnt_r <= bitCnt_r + 5'h01;
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0] chSel_r;
  logic [15:0] chOut_r;
  logic [15:0] dacData_r;
  logic [15:0] mask_r;
  logic [15:0] action_r;
  logic [15:0] code_r;
  logic [6:0]  rdAddr_r;
  logic        softRst;
  logic        dataWr;
  logic        wdogKick;
  logic        chOutWr;
  logic [6:0]  statW1c;

  assign softRst  = wrEn && (addr == ADDR_SOFT_RST);
  assign dataWr   = wrEn && (addr == ADDR_DAC_DATA);
  assign wdogKick = wrEn && (addr == ADDR_WDOG_KICK);
  assign chOutWr  = wrEn && (addr == ADDR_CH_OUT);
  assign statW1c  = (wrEn && (addr == ADDR_STATUS)) ? wdata[FAULT_BITS-1:0] : 7'h00;

  always_ff @(posedge clk) begin
    if (!rstn || softRst) begin
      chSel_r   <= REG_RST;
      chOut_r   <= REG_RST;
      dacData_r <= REG_RST;
      mask_r    <= REG_RST;
      action_r  <= REG_RST;
      code_r    <= REG_RST;
      rdAddr_r  <= 7'h00;
    end else begin
      if (wrEn) begin
        unique case (addr)
          ADDR_CH_SEL:   chSel_r   <= wdata;
          ADDR_CH_OUT:   chOut_r   <= wdata;
          ADDR_DAC_DATA: dacData_r <= wdata;
          ADDR_MASK:     mask_r    <= wdata;
          ADDR_ACTION:   action_r  <= wdata;
          ADDR_CODE:     code_r    <= wdata;
          default:       ;
        endcase
      end
      if (rdReq) begin
        rdAddr_r <= addr;
      end
    end
  end

  logic wdogEn;
  logic crcEn;
  logic rampEn;
  logic ioutMode;
  logic [1:0] wdogSel;
  logic [2:0] stepSel;
  logic [3:0] rateSel;
  fmw_action_t respOut;
  fmw_action_t respTemp;
  fmw_action_t respComm;

  assign wdogEn   = chSel_r[CS_WDOG_EN];
  assign wdogSel  = chSel_r[CS_WDOG_PER_LO +: 2];
  assign crcEn    = chSel_r[CS_CRC_EN];
  assign rampEn   = chOut_r[OUT_RAMP_EN];
  assign stepSel  = chOut_r[OUT_STEP_LO +: 3];
  assign rateSel  = chOut_r[OUT_RATE_LO +: 4];
  assign ioutMode = chOut_r[OUT_CURRENT_OUTPUT_EN];
  assign respOut  = fmw_action_t'(action_r[ACT_OUTPUT_LO +: 2]);
  assign respTemp = fmw_action_t'(action_r[ACT_TEMP_LO +: 2]);
  assign respComm = fmw_action_t'(action_r[ACT_COMM_LO +: 2]);

  // ************************************************************
  // Timed output fault filters
  // ************************************************************
  logic [2:0]  timedRaw;
  logic [2:0]  timedHit;
  logic [31:0] filtCnt_r [3];

  assign timedRaw[0] = senseF.openLoad & ioutMode;
  assign timedRaw[1] = senseF.compliance & ioutMode;
  assign timedRaw[2] = senseF.shortCkt & ~ioutMode;

  generate
    for (genvar k = 0; k < 3; k++) begin : gFilt
      assign timedHit[k] = (filtCnt_r[k] == 32'(FILTER_CYC));
      always_ff @(posedge clk) begin
        if (!rstn || !timedRaw[k]) begin
          filtCnt_r[k] <= 32'h00000000;
        end else if (!timedHit[k]) begin
          filtCnt_r[k] <= filtCnt_r[k] + 32'h00000001;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Watchdog
  // ************************************************************
  logic [31:0] wdogCnt_r;
  logic        wdogExp_r;
  logic [31:0] wdogLimit;

  assign wdogLimit = 32'(WDOG_CYC) << wdogSel;

  always_ff @(posedge clk) begin
    if (!rstn || softRst || !wdogEn || wdogKick) begin
      wdogCnt_r <= 32'h00000000;
      wdogExp_r <= 1'b0;
    end else if (wdogCnt_r >= wdogLimit - 32'h00000001) begin
      wdogExp_r <= 1'b1;
    end else begin
      wdogCnt_r <= wdogCnt_r + 32'h00000001;
    end
  end

  // ************************************************************
  // Status, latch and alarm
  // ************************************************************
  fmw_fault_t      active;
  fmw_fault_t      status_r;
  fmw_stat_state_t stState_r;
  logic [15:0]     stCnt_r;
  logic            olLatch_r;
  logic            pg_r;
  logic            alarmCond;

  assign active.openLoad   = timedHit[0];
  assign active.compliance = timedHit[1];
  assign active.overTemp   = senseF.overTemp;
  assign active.wdog       = wdogExp_r;
  assign active.crc        = crcEn & crcErrPulse;
  assign active.shortCkt   = timedHit[2];
  assign active.hsLimit    = senseF.hsLimit;

  // Status held clear for the reset interval
  always_ff @(posedge clk) begin
    if (!rstn || softRst) begin
      stState_r <= ST_CLEAR;
      stCnt_r   <= 16'h0000;
    end else begin
      unique case (stState_r)
        ST_CLEAR: begin
          if (stCnt_r == 16'(STAT_CLR_CYC - 1)) begin
            stState_r <= ST_RUN;
          end else begin
            stCnt_r <= stCnt_r + 16'h0001;
          end
        end
        ST_RUN: stCnt_r <= 16'h0000;
      endcase
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (!rstn || softRst || stState_r == ST_CLEAR) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~fmw_fault_t'(statW1c)) | active;
      if (!wdogEn && !active.wdog) begin
        status_r.wdog <= 1'b0;
      end
    end
  end

  // Open-load latch while converter powers the output
  always_ff @(posedge clk) begin
    if (!rstn || softRst) begin
      olLatch_r <= 1'b0;
    end else if (timedHit[0] && convEn && respOut != ACT_SHUTDOWN) begin
      olLatch_r <= 1'b1;
    end else if (statW1c[0]) begin
      olLatch_r <= 1'b0;
    end
  end

  assign alarmCond = |(fmw_fault_t'(active | fmw_fault_t'({6'h00, olLatch_r}))
                       & ~fmw_fault_t'(mask_r[FAULT_BITS-1:0]));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      alarmO  <= 1'b0;
      alarmOe <= 1'b0;
      pg_r    <= 1'b0;
    end else begin
      alarmO  <= 1'b0;
      alarmOe <= alarmCond;
      pg_r    <= (senseF.posRailOk | ~posRailEn) & (senseF.negRailOk | ~negRailEn);
    end
  end

  // ************************************************************
  // Automatic response selection
  // ************************************************************
  fmw_action_t actSel;
  logic        outFault;
  logic        kill_r;

  assign outFault = |timedHit;

  always_comb begin
    actSel = ACT_NONE;
    if (active.overTemp && respTemp != ACT_NONE) begin
      actSel = respTemp;
    end else if (outFault && respOut != ACT_NONE) begin
      actSel = respOut;
    end else if ((active.wdog || active.crc) && respComm != ACT_NONE) begin
      actSel = respComm;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || softRst || chOutWr) begin
      kill_r <= 1'b0;
    end else if (actSel == ACT_SHUTDOWN) begin
      kill_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      convEn     <= 1'b0;
      ioutEn     <= 1'b0;
      hsLimitSel <= 1'b0;
    end else begin
      convEn     <= chOut_r[OUT_CONV_EN] & ~kill_r;
      ioutEn     <= chOut_r[OUT_CURRENT_OUTPUT_EN] & ~kill_r;
      hsLimitSel <= code_r[CODE_HS_LIMIT];
    end
  end

  // ************************************************************
  // Output code stepper
  // ************************************************************
  logic [31:0] rateCnt_r;
  logic [31:0] ratePeriod;
  logic        tick;
  logic        hold_r;
  logic [15:0] target;
  logic [15:0] stepSz;
  logic [15:0] faultCode;

  assign ratePeriod = 32'(RATE_BASE_CYC) << rateSel;
  assign tick       = rampEn && (rateCnt_r >= ratePeriod - 32'h00000001);
  assign target     = clrF ? 16'h0000 : dacData_r;
  assign stepSz     = 16'h0001 << stepSel;
  assign faultCode  = {code_r[CODE_LO +: 6], CODE_PAD'(0)};

  always_ff @(posedge clk) begin
    if (!rstn || !rampEn || tick) begin
      rateCnt_r <= 32'h00000000;
    end else begin
      rateCnt_r <= rateCnt_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || softRst) begin
      dacCode <= 16'h0000;
      hold_r  <= 1'b0;
    end else if (actSel == ACT_LOAD_CODE) begin
      dacCode <= faultCode;
      hold_r  <= 1'b1;
    end else if (actSel == ACT_ZERO) begin
      dacCode <= 16'h0000;
      hold_r  <= 1'b1;
    end else if (dataWr) begin
      hold_r <= 1'b0;
      if (!rampEn) begin
        dacCode <= wdata;
      end
    end else if (!hold_r) begin
      if (!rampEn) begin
        if (clrF) begin
          dacCode <= 16'h0000;
        end
      end else if (tick) begin
        if (dacCode < target) begin
          dacCode <= (target - dacCode > stepSz) ? dacCode + stepSz : target;
        end else if (dacCode > target) begin
          dacCode <= (dacCode - target > stepSz) ? dacCode - stepSz : target;
        end
      end
    end
  end

  // ************************************************************
  // Readback
  // ************************************************************
  logic [15:0] rdData;
  logic [23:0] sdoSh_r;

  always_comb begin
    rdData = 16'h0000;
    unique case (rdAddr_r)
      ADDR_CH_SEL:   rdData = chSel_r;
      ADDR_CH_OUT:   rdData = chOut_r;
      ADDR_DAC_DATA: rdData = dacData_r;
      ADDR_STATUS:   rdData = {8'h00, pg_r, status_r};
      ADDR_MASK:     rdData = mask_r;
      ADDR_ACTION:   rdData = action_r;
      ADDR_CODE:     rdData = code_r;
      default:       rdData = 16'h0000;
    endcase
  end

  // Data leaves MSB first, moved on rising serial clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sdoSh_r <= 24'h000000;
      sdoO    <= 1'b0;
      sdoOe   <= 1'b0;
    end else if (syncFall) begin
      sdoO    <= 1'b0;
      sdoSh_r <= {rdAddr_r, rdData, 1'b0};
      sdoOe   <= 1'b1;
    end else if (syncRise) begin
      sdoOe <= 1'b0;
    end else if (!syncF && sclkRise) begin
      sdoO    <= sdoSh_r[23];
      sdoSh_r <= {sdoSh_r[22:0], 1'b0};
    end
  end

endmodule

// ===== fmw_fault_monitor_chk.sv
// Port checker for the fault monitor
`timescale 1ns/1ps
module fmw_fault_monitor_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Serial and alarm pins
  input wire logic        syncN,
  input wire logic        sdoOe,
  input wire logic        alarmO,
  input wire logic        alarmOe,
  // Converter control
  input wire logic        convEn,
  input wire logic        ioutEn,
  input wire logic        hsLimitSel,
  input wire logic [15:0] dacCode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ************************************************************
  // Frame select windows
  // ************************************************************
  sequence quiet_s; syncN [*6]; endsequence
  sequence framed_s; !syncN [*6]; endsequence
  alarm_data_low_a: assert property (alarmO == 1'b0)
    else $error("alarm data not low");
  reset_clean_a: assert property (!$past(rstn) |-> !alarmOe && !convEn && !ioutEn && dacCode == 16'h0000)
    else $error("outputs not cleared by reset");
  sdo_drive_a: assert property (framed_s |-> sdoOe)
    else $error("sdo not driven in frame");
  sdo_release_a: assert property (quiet_s |-> !sdoOe)
    else $error("sdo driven outside frame");
  sdo_cause_a: assert property ($rose(sdoOe) |-> !$past(syncN, 2))
    else $error("sdo enabled without frame");
  limit_write_a: assert property ($changed(hsLimitSel) |-> $past(syncN, 3))
    else $error("limit select changed without frame");
  conv_write_a: assert property ($rose(convEn) |-> $past(syncN, 3))
    else $error("converter enabled without frame");
  current_output_write_a: assert property ($rose(ioutEn) |-> $past(syncN, 3))
    else $error("amplifier enabled without frame");
endmodule

// ===== fmw_host_model.sv
// Behavioural host driving the serial register port
`timescale 1ns/1ps
module fmw_host_model (
  // Serial pins
  output logic      sclk,
  output logic      syncN,
  output logic      sdin,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b1;
    syncN = 1'b1;
    sdin = 1'b0;
  end
  // One frame, MSB first, answer taken on falling clock
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    syncN = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdin = tx[i];
      #80 sclk = 1'b0;
      rx[i] = sdo;
      #80 sclk = 1'b1;
    end
    #80 syncN = 1'b1;
    sdin = ~sdin;
    #160;
  endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the fault monitor
`timescale 1ns/1ps
module tb_top;
  import fmw_pkg::*;
  logic clk, rstn, crcErrPulse, clearIn, posRailEn, negRailEn, sclk, syncN, sdin, sdoO, sdoOe;
  logic alarmO, alarmOe, convEn, ioutEn, hsLimitSel;
  logic [15:0] dacCode, rdv;
  fmw_sense_t sense;
  wire sdoW = sdoOe ? sdoO : 1'bz;
  int numErrors = 0;
  int samplesChecked = 0;
  fmw_fault_monitor #(.FILTER_CYC(50), .WDOG_CYC(200), .RATE_BASE_CYC(4)) dut_u (
    .clk(clk), .rstn(rstn), .sclk(sclk), .syncN(syncN), .sdin(sdin), .sdoO(sdoO), .sdoOe(sdoOe),
    .sense(sense), .posRailEn(posRailEn), .negRailEn(negRailEn), .crcErrPulse(crcErrPulse),
    .clearIn(clearIn), .alarmO(alarmO), .alarmOe(alarmOe), .dacCode(dacCode), .convEn(convEn),
    .ioutEn(ioutEn), .hsLimitSel(hsLimitSel));
  fmw_host_model host_u (.sclk(sclk), .syncN(syncN), .sdin(sdin), .sdo(sdoW));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [23:0] r;
    host_u.xfer({1'b0, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [23:0] r;
    host_u.xfer({1'b1, a, 16'h0000}, r);
    host_u.xfer(24'h000000, r);
    d = r[15:0];
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic regs_test();
    rd(ADDR_MASK, rdv); chk("mask reset", REG_RST, rdv);
    wr(ADDR_MASK, 16'h007f); rd(ADDR_MASK, rdv); chk("mask", 16'h007f, rdv);
    rd(7'h7f, rdv); chk("unmapped", 16'h0000, rdv);
    rd(ADDR_STATUS, rdv); chk("supply good", 16'h0080, rdv);
    posRailEn = 1'b1;
    rd(ADDR_STATUS, rdv); chk("rail low", 16'h0000, rdv);
    posRailEn = 1'b0;
    wr(ADDR_MASK, 16'h0000);
  endtask
  task automatic overtemp_test();
    wr(ADDR_CODE, 16'h2a20); wr(ADDR_ACTION, 16'h0004);
    chk("limit sel", 16'h0001, {15'h0, hsLimitSel});
    sense.overTemp = 1'b1; cyc(8);
    chk("alarm on", 16'h0001, {15'h0, alarmOe});
    chk("fault code", {6'h2a, 10'h000}, dacCode);
    sense.overTemp = 1'b0; cyc(8);
    chk("alarm off", 16'h0000, {15'h0, alarmOe});
    chk("code kept", {6'h2a, 10'h000}, dacCode);
    rd(ADDR_STATUS, rdv); chk("sticky", 16'h0084, rdv);
    wr(ADDR_STATUS, 16'h0004); rd(ADDR_STATUS, rdv); chk("w1c", 16'h0080, rdv);
    wr(ADDR_MASK, 16'h0004); sense.overTemp = 1'b1; cyc(8);
    chk("masked", 16'h0000, {15'h0, alarmOe});
    sense.overTemp = 1'b0; wr(ADDR_SOFT_RST, 16'h0000);
    chk("soft reset code", 16'h0000, dacCode);
    rd(ADDR_MASK, rdv); chk("soft reset mask", REG_RST, rdv);
  endtask
  task automatic openload_test();
    wr(ADDR_CH_OUT, 16'h3000); cyc(800);
    sense.openLoad = 1'b1; cyc(30); sense.openLoad = 1'b0; cyc(8);
    chk("brief open", 16'h0000, {15'h0, alarmOe});
    sense.openLoad = 1'b1; cyc(62);
    chk("open load", 16'h0001, {15'h0, alarmOe});
    sense.openLoad = 1'b0; cyc(20);
    chk("latched", 16'h0001, {15'h0, alarmOe});
    wr(ADDR_STATUS, 16'h0001);
    chk("unlatched", 16'h0000, {15'h0, alarmOe});
  endtask
  task automatic wdog_test();
    wr(ADDR_CH_SEL, 16'h0007); wr(ADDR_WDOG_KICK, 16'h0000); wr(ADDR_WDOG_KICK, 16'h0000);
    chk("kicked", 16'h0000, {15'h0, alarmOe});
    cyc(1700);
    rd(ADDR_STATUS, rdv); chk("timeout", 16'h0088, rdv);
    wr(ADDR_CH_SEL, 16'h0008);
    rd(ADDR_STATUS, rdv); chk("wdog off", 16'h0080, rdv);
    cyc(1); crcErrPulse = 1'b1; cyc(1); crcErrPulse = 1'b0;
    rd(ADDR_STATUS, rdv); chk("frame error", 16'h0090, rdv);
  endtask
  task automatic ramp_test();
    logic [15:0] v;
    wr(ADDR_CH_OUT, 16'h0013); wr(ADDR_DAC_DATA, 16'h0040);
    chk("ramping", 16'h0001, {15'h0, dacCode < 16'h0040});
    cyc(40); chk("ramp end", 16'h0040, dacCode);
    clearIn = 1'b1; cyc(50); chk("ramp clear", 16'h0000, dacCode);
    clearIn = 1'b0; wr(ADDR_CH_OUT, 16'h0010); wr(ADDR_DAC_DATA, 16'h0400); wr(ADDR_CH_OUT, 16'h0000);
    v = dacCode; cyc(40);
    chk("ramp abort", v, dacCode);
    chk("abort range", 16'h0001, {15'h0, v > 16'h0040 && v < 16'h0400});
    clearIn = 1'b1; cyc(8); chk("clear direct", 16'h0000, dacCode);
    clearIn = 1'b0;
  endtask
  task automatic shutdown_test();
    wr(ADDR_ACTION, 16'h0002); wr(ADDR_CH_OUT, 16'h3000);
    chk("conv on", 16'h0003, {14'h0, convEn, ioutEn});
    sense.openLoad = 1'b1; cyc(62);
    chk("conv off", 16'h0000, {14'h0, convEn, ioutEn});
    chk("alarm open", 16'h0001, {15'h0, alarmOe});
    sense.openLoad = 1'b0; cyc(20);
    chk("no latch", 16'h0000, {15'h0, alarmOe});
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0; crcErrPulse = 1'b0; clearIn = 1'b0; posRailEn = 1'b0; negRailEn = 1'b0; sense = '0;
    cyc(8); rstn = 1'b1; cyc(10);
    regs_test();
    overtemp_test();
    openload_test();
    wdog_test();
    ramp_test();
    shutdown_test();
    summarize();
  end
  initial begin
    #400000;
    numErrors++;
    summarize();
  end
endmodule
bind fmw_fault_monitor fmw_fault_monitor_chk chk_u (.clk(clk), .rstn(rstn), .syncN(syncN), .sdoOe(sdoOe),
  .alarmO(alarmO), .alarmOe(alarmOe), .convEn(convEn), .ioutEn(ioutEn), .hsLimitSel(hsLimitSel), .dacCode(dacCode));
